// *** verilog/csv_ctrl.sv ***
// comparator output sync, timer1 source select and reference ladder control
//
// Chosen here: the APB register port and the register offsets.
module csv_ctrl (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cmp_raw_out,
    input wire logic high_freq_internal_osc,
    input wire logic timer_gate_pin,
    input wire logic [1:0] timer_prescale,
    output logic cmp_presented_out,
    output logic timer_gate,
    output logic timer_count_pulse,
    output logic timer_source_clk,
    output logic hysteresis_enable,
    output logic [3:0] ladder_level_code,
    output logic ladder_range_select,
    output logic ladder_reference_enable,
    output logic fixed_reference_enable,
    output logic [1:0] ref_select
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [7:0] comparator_control_two;
    logic [7:0] reference_ladder_control;
    logic src_level;
    logic pre_level;
    logic pre_level_d;
    logic pre_rise;
    logic pre_fall;
    logic cmp_latch;
    logic next_cmp_out;
    logic wr_access;
    logic setup_phase;
    logic [31:0] next_rdata;
    logic next_err;
    csv_pkg::csv_ref_sel_t next_ref_sel;
    logic next_fixed_on;

    // one address decoder shared by the write and the read paths
    function automatic logic addr_is(input logic [11:0] a, input logic [11:0] target);
        addr_is = (a == target);
    endfunction

    function automatic logic addr_known(input logic [11:0] a);
        addr_known = addr_is(a, csv_pkg::ADDR_CMP_CTRL) || addr_is(a, csv_pkg::ADDR_REF_CTRL)
            || addr_is(a, csv_pkg::ADDR_STATUS);
    endfunction

    // ------------------------------------------------------------
    // apb slave: no wait state, read data still leaves a flip-flop
    // ------------------------------------------------------------
    assign setup_phase = psel && !penable;
    assign wr_access = psel && penable && pready && pwrite;

    // pready rises in the first access cycle and drops right after
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            pready <= 1'b0;
        else
            pready <= setup_phase;
    end

    // unmapped address answers with an error, writes there change nothing
    always_comb
    begin
        next_err = !addr_known(paddr);
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
            pslverr <= 1'b0;
        else if (setup_phase)
            pslverr <= next_err;
        else
            pslverr <= 1'b0;
    end

    // read mux; unimplemented bits are masked to zero
    always_comb
    begin
        next_rdata = 32'h0000_0000;
        if (addr_is(paddr, csv_pkg::ADDR_CMP_CTRL))
            next_rdata[7:0] = comparator_control_two & csv_pkg::CMP_CTRL_MASK;
        else if (addr_is(paddr, csv_pkg::ADDR_REF_CTRL))
            next_rdata[7:0] = reference_ladder_control & csv_pkg::REF_CTRL_MASK;
        else if (addr_is(paddr, csv_pkg::ADDR_STATUS))
        begin
            next_rdata[csv_pkg::ST_CMP_BIT] = cmp_presented_out;
            next_rdata[csv_pkg::ST_SRC_BIT] = src_level;
            next_rdata[csv_pkg::ST_PRE_BIT] = pre_level;
            next_rdata[csv_pkg::ST_SEL_LSB +: 2] = ref_select;
            next_rdata[csv_pkg::ST_FIXED_BIT] = fixed_reference_enable;
        end
    end

    // read data is sampled in the setup phase and held for the access
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            prdata <= 32'h0000_0000;
        else if (setup_phase && !pwrite)
            prdata <= next_rdata;
    end

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    // write mask keeps the unimplemented bits at zero whatever is written
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            comparator_control_two <= csv_pkg::CMP_CTRL_RESET;
        else if (wr_access && addr_is(paddr, csv_pkg::ADDR_CMP_CTRL))
            comparator_control_two <= pwdata[7:0] & csv_pkg::CMP_CTRL_MASK;
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
            reference_ladder_control <= csv_pkg::REF_CTRL_RESET;
        else if (wr_access && addr_is(paddr, csv_pkg::ADDR_REF_CTRL))
            reference_ladder_control <= pwdata[7:0] & csv_pkg::REF_CTRL_MASK;
    end

    // ------------------------------------------------------------
    // timer clock source and prescaler
    // ------------------------------------------------------------
    csv_tmr_clk u_tmr_clk (
        .clk_sys(clk_sys),
        .rst(rst),
        .alt_select(comparator_control_two[csv_pkg::ALT_BIT]),
        .prescale(timer_prescale),
        .src_level(src_level),
        .pre_level(pre_level)
    );

    // edge detector on the prescaled clock
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            pre_level_d <= 1'b0;
        else
            pre_level_d <= pre_level;
    end

    assign pre_rise = pre_level && !pre_level_d;
    assign pre_fall = !pre_level && pre_level_d;

    // source clock mirrored to timer1 from a flip-flop
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            timer_source_clk <= 1'b0;
        else
            timer_source_clk <= src_level;
    end

    // count on the rising edge so the falling-edge capture never races it
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            timer_count_pulse <= 1'b0;
        else
            timer_count_pulse <= pre_rise;
    end

    // ------------------------------------------------------------
    // comparator output synchronisation
    // ------------------------------------------------------------
    // latch follows the comparator only at the prescaled falling edge
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            cmp_latch <= 1'b0;
        else if (pre_fall)
            cmp_latch <= cmp_raw_out;
    end

    // the latch is bypassed in async mode; the input is already synchronous
    always_comb
    begin
        if (comparator_control_two[csv_pkg::SYNC_BIT])
            next_cmp_out = pre_fall ? cmp_raw_out : cmp_latch;
        else
            next_cmp_out = cmp_raw_out;
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
            cmp_presented_out <= 1'b0;
        else
            cmp_presented_out <= next_cmp_out;
    end

    // gate follows the presented output so sync mode also protects the gate
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            timer_gate <= 1'b0;
        else if (comparator_control_two[csv_pkg::GATE_BIT])
            timer_gate <= timer_gate_pin;
        else
            timer_gate <= next_cmp_out;
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
            hysteresis_enable <= 1'b0;
        else
            hysteresis_enable <= comparator_control_two[csv_pkg::HYS_BIT];
    end

    // ------------------------------------------------------------
    // reference ladder and fixed reference
    // ------------------------------------------------------------
    // level code and range pass straight to the ladder
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            ladder_level_code <= 4'h0;
            ladder_range_select <= 1'b0;
        end
        else
        begin
            ladder_level_code <= reference_ladder_control[csv_pkg::LEVEL_LSB +: csv_pkg::LEVEL_W];
            ladder_range_select <= reference_ladder_control[csv_pkg::RANGE_BIT];
        end
    end

    // ladder power depends on this register alone, never on comparator bits
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            ladder_reference_enable <= 1'b0;
        else
            ladder_reference_enable <= reference_ladder_control[csv_pkg::LADDER_BIT];
    end

    // the fast internal oscillator forces the fixed reference on;
    // software still owns the settling wait after turning it on
    assign next_fixed_on = reference_ladder_control[csv_pkg::FIXED_BIT]
        || high_freq_internal_osc;

    always_ff @(posedge clk_sys)
    begin
        if (rst)
            fixed_reference_enable <= 1'b0;
        else
            fixed_reference_enable <= next_fixed_on;
    end

    // ground wins only when both enable bits are clear
    always_comb
    begin
        if (reference_ladder_control[csv_pkg::LADDER_BIT])
            next_ref_sel = csv_pkg::REF_LADDER;
        else if (reference_ladder_control[csv_pkg::FIXED_BIT])
            next_ref_sel = csv_pkg::REF_FIXED;
        else
            next_ref_sel = csv_pkg::REF_GROUND;
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
            ref_select <= csv_pkg::REF_GROUND;
        else
            ref_select <= next_ref_sel;
    end

endmodule

// *** verilog/csv_pkg.sv ***
// constants shared by the comparator sync and reference ladder control block
package csv_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses on the apb bus)
    // ------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] ADDR_CMP_CTRL = 12'h000; // comparator_control_two
    localparam logic [ADDR_W-1:0] ADDR_REF_CTRL = 12'h004; // reference_ladder_control
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 12'h008;   // live state, read only

    // ------------------------------------------------------------
    // comparator_control_two fields
    // ------------------------------------------------------------
    localparam int SYNC_BIT = 0;   // output_sync_select
    localparam int GATE_BIT = 1;   // timer_gate_source_select
    localparam int HYS_BIT = 3;    // hysteresis_enable
    localparam int ALT_BIT = 4;    // timer_alt_clock_select
    localparam logic [7:0] CMP_CTRL_MASK = 8'h1b;
    localparam logic [7:0] CMP_CTRL_RESET = 8'h00;

    // ------------------------------------------------------------
    // reference_ladder_control fields
    // ------------------------------------------------------------
    localparam int LEVEL_LSB = 0;  // ladder_level_code, four bits
    localparam int LEVEL_W = 4;
    localparam int FIXED_BIT = 4;  // fixed_reference_enable
    localparam int RANGE_BIT = 5;  // ladder_range_select, one = low range
    localparam int LADDER_BIT = 7; // ladder_reference_enable
    localparam logic [7:0] REF_CTRL_MASK = 8'hbf;
    localparam logic [7:0] REF_CTRL_RESET = 8'h00;

    // ------------------------------------------------------------
    // status register fields
    // ------------------------------------------------------------
    localparam int ST_CMP_BIT = 0;     // comparator output as presented
    localparam int ST_SRC_BIT = 1;     // timer source clock level
    localparam int ST_PRE_BIT = 2;     // prescaled timer clock level
    localparam int ST_SEL_LSB = 3;     // reference selection, two bits
    localparam int ST_FIXED_BIT = 5;   // fixed reference running

    // ------------------------------------------------------------
    // timer clock source: half periods in system clock cycles
    // ------------------------------------------------------------
    localparam int HALF_W = 3;
    localparam logic [HALF_W-1:0] HALF_FAST = 3'h1;  // oscillator rate
    localparam logic [HALF_W-1:0] HALF_SLOW = 3'h4;  // instruction rate, one quarter

    // reference presented to the comparator
    typedef enum logic [1:0] {
        REF_GROUND = 2'h0,
        REF_FIXED = 2'h1,
        REF_LADDER = 2'h2
    } csv_ref_sel_t;

endpackage

// *** verilog/csv_tmr_clk.sv ***
// timer clock source generator with prescaler
module csv_tmr_clk (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic alt_select,
    input wire logic [1:0] prescale,
    output logic src_level,
    output logic pre_level
);

    logic [csv_pkg::HALF_W-1:0] half_cnt;
    logic [csv_pkg::HALF_W-1:0] half_len;
    logic [2:0] pre_cnt;
    logic src_rise;

    // oscillator rate when the alternate select is set, else one quarter of it
    assign half_len = alt_select ? csv_pkg::HALF_FAST : csv_pkg::HALF_SLOW;
    assign src_rise = (half_cnt == half_len - 3'h1) && !src_level;

    // ------------------------------------------------------------
    // source clock divider
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            half_cnt <= 3'h0;
            src_level <= 1'b0;
        end
        else if (half_cnt >= half_len - 3'h1)
        begin
            // >= so a switch to the fast rate never strands the count
            half_cnt <= 3'h0;
            src_level <= !src_level;
        end
        else
        begin
            half_cnt <= half_cnt + 3'h1;
        end
    end

    // prescaler counts source rising edges; its bits are divided clocks
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            pre_cnt <= 3'h0;
        else if (src_rise)
            pre_cnt <= pre_cnt + 3'h1;
    end

    // the capture edge is taken after the prescaler, not from the raw source
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            pre_level <= 1'b0;
        else if (prescale == 2'h0)
            pre_level <= (src_rise || src_level) && !(half_cnt >= half_len - 3'h1 && src_level);
        else
            pre_level <= pre_cnt[prescale - 2'h1];
    end

endmodule

// *** bench/csv_ctrl_checker.sv ***
// assertion checker for the comparator sync and reference control block
module csv_ctrl_checker (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic cmp_raw_out,
    input wire logic high_freq_internal_osc,
    input wire logic timer_gate_pin,
    input wire logic [1:0] timer_prescale,
    input wire logic cmp_presented_out,
    input wire logic timer_gate,
    input wire logic timer_count_pulse,
    input wire logic timer_source_clk,
    input wire logic hysteresis_enable,
    input wire logic [3:0] ladder_level_code,
    input wire logic ladder_range_select,
    input wire logic ladder_reference_enable,
    input wire logic fixed_reference_enable,
    input wire logic [1:0] ref_select
);
    logic wr_cmp, wr_ref, rd, sync_on, gate_on, alt_on;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    // completed transfers, seen at the edge where pready is high
    assign rd = psel && penable && pready && !pwrite;
    assign wr_cmp = psel && penable && pready && pwrite && paddr == csv_pkg::ADDR_CMP_CTRL;
    assign wr_ref = psel && penable && pready && pwrite && paddr == csv_pkg::ADDR_REF_CTRL;

    // shadow of the mode bits, so mode-dependent checks know what is selected
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            {alt_on, gate_on, sync_on} <= 3'h0;
        else if (wr_cmp)
            {alt_on, gate_on, sync_on} <= {pwdata[4], pwdata[1], pwdata[0]};
    end

    chk_hys_follow: assert property (wr_cmp |-> ##2 hysteresis_enable == $past(pwdata[3], 2))
        else $error("hysteresis enable does not follow its bit");
    chk_ladder_drive: assert property (wr_ref |-> ##2 {ladder_reference_enable,
        ladder_range_select, ladder_level_code} == $past({pwdata[7], pwdata[5], pwdata[3:0]}, 2))
        else $error("ladder outputs differ from written value");
    chk_ground_sel: assert property (wr_ref && !pwdata[7] && !pwdata[4]
        |-> ##2 ref_select == csv_pkg::REF_GROUND) else $error("ground not selected");
    chk_ladder_route: assert property (ladder_reference_enable
        |-> ref_select == csv_pkg::REF_LADDER) else $error("ladder enabled but not routed");
    chk_fixed_bit: assert property (wr_ref |-> ##2 fixed_reference_enable ==
        ($past(pwdata[4], 2) || $past(high_freq_internal_osc))) else $error("fixed enable wrong");
    chk_fixed_forced: assert property (high_freq_internal_osc [*3]
        |-> fixed_reference_enable) else $error("fixed reference off while osc runs");
    chk_async_pass: assert property ((!sync_on) [*3]
        |-> cmp_presented_out == $past(cmp_raw_out)) else $error("unsynced output resampled");
    chk_fast_clk: assert property (alt_on [*3] ##0 $rose(timer_source_clk)
        |=> !timer_source_clk) else $error("oscillator source half period wrong");
    chk_slow_clk: assert property ((!alt_on) [*8] ##0 $rose(timer_source_clk)
        |-> timer_source_clk [*4] ##1 !timer_source_clk) else $error("quarter source wrong");
    chk_gate_pin: assert property (gate_on [*3]
        |-> timer_gate == $past(timer_gate_pin)) else $error("gate not taken from pin");
    chk_unused_bits: assert property (rd |-> prdata[31:8] == 24'h0 &&
        !(paddr == csv_pkg::ADDR_CMP_CTRL && (prdata[7:5] != 3'h0 || prdata[2])) &&
        !(paddr == csv_pkg::ADDR_REF_CTRL && prdata[6])) else $error("unused bit reads one");
endmodule

// *** bench/csv_far_model.sv ***
// far-side model: analog comparator and the timer counter it gates
module csv_far_model (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [7:0] in_pos,
    input wire logic [7:0] in_neg,
    input wire logic hysteresis_enable,
    input wire logic timer_gate,
    input wire logic timer_count_pulse,
    output logic cmp_raw_out,
    output logic [15:0] timer_count
);
    // with hysteresis the output flips only past a margin of two steps
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            cmp_raw_out <= 1'b0;
        else if (!hysteresis_enable || in_pos > in_neg + 8'h02 || in_pos + 8'h02 < in_neg)
            cmp_raw_out <= in_pos > in_neg;
    end

    // counts only on the rising-edge pulse, never on the capture edge
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            timer_count <= 16'h0000;
        else if (timer_count_pulse && timer_gate)
            timer_count <= timer_count + 16'h0001;
    end
endmodule

// *** bench/tb_comparator_sync_vref_control.sv ***
// self-checking bench for the comparator sync and reference control block
module tb_comparator_sync_vref_control;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic psel, penable, pwrite, pready, pslverr, high_freq_internal_osc, timer_gate_pin;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [1:0] timer_prescale, ref_select;
    logic [7:0] in_pos, in_neg;
    logic cmp_raw_out, cmp_presented_out, timer_gate, timer_count_pulse, timer_source_clk;
    logic hysteresis_enable, ladder_range_select, ladder_reference_enable;
    logic fixed_reference_enable;
    logic [3:0] ladder_level_code;
    logic [15:0] timer_count;
    int err_total = 0;
    int samples_checked = 0;

    always #2.5 clk_sys = ~clk_sys;

    csv_ctrl csv_ctrl_i (.*);
    csv_far_model csv_far_model_i (.*);

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] %0t ns: got %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic print_verdict();
        $display("mismatches %0d, comparisons %0d", err_total, samples_checked);
        if (err_total == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // one transfer; the request is held until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
        output logic [31:0] q, output logic e);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge clk_sys);
        penable <= 1'b1;
        for (n = 0; n < 16 && (n == 0 || pready !== 1'b1); n++)
            @(posedge clk_sys);
        if (pready !== 1'b1)
        begin
            err_total++;
            print_verdict();
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic experr);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 8'h00, q, e);
        chk(q, exp);
        chk(32'(e), 32'(experr));
    endtask

    // bounded wait for a level; running out counts as a mismatch
    task automatic wait_for(ref logic s, input int lim);
        int n;
        for (n = 0; n < lim && s !== 1'b1; n++)
            @(posedge clk_sys);
        if (s !== 1'b1)
        begin
            err_total++;
            print_verdict();
        end
    endtask

    // masks, an unmapped slot, and a reset in mid-run clearing everything
    task automatic t_regs();
        wr(csv_pkg::ADDR_CMP_CTRL, 8'hff);
        wr(csv_pkg::ADDR_REF_CTRL, 8'hff);
        wr(12'h00c, 8'hff);
        rd(csv_pkg::ADDR_CMP_CTRL, 32'h1b, 1'b0);
        rd(csv_pkg::ADDR_REF_CTRL, 32'hbf, 1'b0);
        rd(12'h00c, 32'h0, 1'b1);
        chk(32'(hysteresis_enable), 32'h1);
        rst <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        rd(csv_pkg::ADDR_CMP_CTRL, 32'h0, 1'b0);
        rd(csv_pkg::ADDR_REF_CTRL, 32'h0, 1'b0);
    endtask

    // ladder code, range and routing; ends at all-clear to see the osc forcing
    task automatic t_ref();
        logic [7:0] v [4] = '{8'h10, 8'hbf, 8'ha5, 8'h00};
        logic [31:0] q;
        logic e;
        foreach (v[i])
        begin
            wr(csv_pkg::ADDR_REF_CTRL, v[i]);
            repeat (3) @(posedge clk_sys);
            chk(32'({ladder_reference_enable, ladder_range_select, fixed_reference_enable,
                ladder_level_code}), 32'({v[i][7], v[i][5:4], v[i][3:0]}));
            chk(32'(ref_select), v[i][7] ? 32'h2 : 32'(v[i][4]));
        end
        high_freq_internal_osc <= 1'b1;
        repeat (3) @(posedge clk_sys);
        chk(32'({fixed_reference_enable, ref_select}), 32'h4);
        // status word: timer clock levels run free, so bits 2:1 are masked
        apb(1'b0, csv_pkg::ADDR_STATUS, 8'h00, q, e);
        chk(q & 32'hffff_fff9, 32'h0000_0020);
        chk(32'(e), 32'h0);
        high_freq_internal_osc <= 1'b0;
    endtask

    // pulses in 64 cycles for every prescale at both sources (periods 2 and 8)
    task automatic t_rates();
        int c;
        for (int a = 0; a < 2; a++)
            for (int p = 0; p < 4; p++)
            begin
                wr(csv_pkg::ADDR_CMP_CTRL, a ? 8'h10 : 8'h00);
                timer_prescale <= p[1:0];
                repeat (70) @(posedge clk_sys);
                c = 0;
                repeat (64)
                begin
                    @(posedge clk_sys);
                    c += int'(timer_count_pulse === 1'b1);
                end
                chk(32'(c), a ? 32'(32 >> p) : 32'(8 >> p));
            end
    endtask

    // a change just after a count edge must wait for the prescaled fall
    task automatic t_sync();
        wr(csv_pkg::ADDR_CMP_CTRL, 8'h01);
        timer_prescale <= 2'h3;
        repeat (70) @(posedge clk_sys);
        wait_for(timer_count_pulse, 100);
        in_pos <= 8'h90;
        repeat (12) @(posedge clk_sys);
        chk(32'(cmp_presented_out), 32'h0);
        wait_for(cmp_presented_out, 60);
        wr(csv_pkg::ADDR_CMP_CTRL, 8'h00);
        in_pos <= 8'h70;
        repeat (3) @(posedge clk_sys);
        chk(32'(cmp_presented_out), 32'h0);
    endtask

    // timer count stalls or runs as the chosen gate source says
    task automatic t_gate();
        logic [15:0] c0;
        wr(csv_pkg::ADDR_CMP_CTRL, 8'h12);
        timer_prescale <= 2'h0;
        repeat (4) @(posedge clk_sys);
        c0 = timer_count;
        repeat (64) @(posedge clk_sys);
        chk(32'(timer_count), 32'(c0));
        timer_gate_pin <= 1'b1;
        repeat (64) @(posedge clk_sys);
        chk(32'(timer_count - c0 > 16'h0010), 32'h1);
        wr(csv_pkg::ADDR_CMP_CTRL, 8'h10);
        repeat (4) @(posedge clk_sys);
        c0 = timer_count;
        repeat (64) @(posedge clk_sys);
        chk(32'(timer_count), 32'(c0));
    endtask

    initial
    begin
        {psel, penable, pwrite, high_freq_internal_osc, timer_gate_pin} = 5'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        timer_prescale = 2'h0;
        in_pos = 8'h70;
        in_neg = 8'h80;
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        t_regs();
        t_ref();
        t_rates();
        t_sync();
        t_gate();
        print_verdict();
    end
endmodule

bind csv_ctrl csv_ctrl_checker csv_ctrl_checker_i (.*);
